// ===== src/lspwm_ctrl.v
// led sequence state machine with current and pulse width control
`timescale 1ns/10ps
`include "lspwm_regs.vh"
module lspwm_ctrl #(
  parameter DIV_W = 4,
  parameter PER_W = 12,
  parameter EN_W  = 7
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        lineStartInput,
  input  wire        transferGateInput,
  output reg         ledRedOn,
  output reg         ledGreenOn,
  output reg         ledBlueOn,
  output reg         shuntOn,
  output reg  [7:0]  idacCode,
  output reg  [1:0]  ledCurrentRange,
  output reg         blankActive
);

  localparam integer BLANK_INT = `LSPWM_BLANK_CYC;
  localparam [15:0]  BLANK_CYC = BLANK_INT[15:0];

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [31:0] ctrl_reg;
  reg  [31:0] map_reg;
  reg  [31:0] idac_reg;
  reg  [31:0] period_reg;
  reg  [31:0] dutyR_reg;
  reg  [31:0] dutyG_reg;
  reg  [31:0] dutyB_reg;
  reg  [31:0] enable_reg;
  reg  [1:0]  lsSync_reg;
  reg  [1:0]  tgSync_reg;
  reg         tgDelay_reg;
  reg  [1:0]  seqIdx_reg;
  reg         done_reg;
  reg  [15:0] blankCnt_reg;
  reg  [31:0] rdData_next;
  reg  [PER_W-1:0] duty_next;
  reg  [1:0]  range_next;
  wire        busReq;
  wire        busWrite;
  wire        lsLevel;
  wire        tgLevel;
  wire        startCond;
  wire        tgRise;
  wire        monoMode;
  wire [1:0]  lastState;
  wire [1:0]  mapSel;
  wire        advance;
  wire        blankStart;
  wire        blank;
  wire        pulseLevel;
  wire        pulseGate;
  wire        enableDone;
  wire        lit;

  // ----------------------------------------------------------------------
  // byte-lane merge for register writes
  // ----------------------------------------------------------------------
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  sel;
    integer      i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // wishbone slave, one wait state
  // ----------------------------------------------------------------------
  assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite = busReq && wb_we_i;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= `LSPWM_RST_CTRL;
      map_reg    <= `LSPWM_RST_MAP;
      idac_reg   <= `LSPWM_RST_IDAC;
      period_reg <= `LSPWM_RST_PERIOD;
      dutyR_reg  <= `LSPWM_RST_DUTY;
      dutyG_reg  <= `LSPWM_RST_DUTY;
      dutyB_reg  <= `LSPWM_RST_DUTY;
      enable_reg <= `LSPWM_RST_ENABLE;
    end else if (busWrite) begin
      case (wb_adr_i)
        `LSPWM_ADDR_CTRL: begin
          ctrl_reg <= mergeBytes(ctrl_reg, wb_dat_i, wb_sel_i) &
                      32'h0000_0007;
        end
        `LSPWM_ADDR_MAP: begin
          map_reg <= mergeBytes(map_reg, wb_dat_i, wb_sel_i) &
                     32'h0000_00FF;
        end
        `LSPWM_ADDR_IDAC: begin
          idac_reg <= mergeBytes(idac_reg, wb_dat_i, wb_sel_i) &
                      32'h0000_3FFF;
        end
        `LSPWM_ADDR_PERIOD: begin
          period_reg <= mergeBytes(period_reg, wb_dat_i, wb_sel_i) &
                        32'h0000_FFFF;
        end
        `LSPWM_ADDR_DUTY_R: begin
          dutyR_reg <= mergeBytes(dutyR_reg, wb_dat_i, wb_sel_i) &
                       32'h0000_0FFF;
        end
        `LSPWM_ADDR_DUTY_G: begin
          dutyG_reg <= mergeBytes(dutyG_reg, wb_dat_i, wb_sel_i) &
                       32'h0000_0FFF;
        end
        `LSPWM_ADDR_DUTY_B: begin
          dutyB_reg <= mergeBytes(dutyB_reg, wb_dat_i, wb_sel_i) &
                       32'h0000_0FFF;
        end
        `LSPWM_ADDR_ENABLE: begin
          enable_reg <= mergeBytes(enable_reg, wb_dat_i, wb_sel_i) &
                        32'h0000_7F7F;
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  always @* begin
    rdData_next = 32'h0000_0000;
    case (wb_adr_i)
      `LSPWM_ADDR_CTRL:   rdData_next = ctrl_reg;
      `LSPWM_ADDR_MAP:    rdData_next = map_reg;
      `LSPWM_ADDR_IDAC:   rdData_next = idac_reg;
      `LSPWM_ADDR_PERIOD: rdData_next = period_reg;
      `LSPWM_ADDR_DUTY_R: rdData_next = dutyR_reg;
      `LSPWM_ADDR_DUTY_G: rdData_next = dutyG_reg;
      `LSPWM_ADDR_DUTY_B: rdData_next = dutyB_reg;
      `LSPWM_ADDR_ENABLE: rdData_next = enable_reg;
      `LSPWM_ADDR_STATUS: begin
        rdData_next = {24'h00_0000, blankActive, ledBlueOn, ledGreenOn,
                       ledRedOn, pulseGate, done_reg, seqIdx_reg};
      end
      default:            rdData_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= rdData_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // timing pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lsSync_reg  <= 2'h0;
      tgSync_reg  <= 2'h0;
      tgDelay_reg <= 1'b0;
    end else begin
      lsSync_reg  <= {lsSync_reg[0], lineStartInput};
      tgSync_reg  <= {tgSync_reg[0], transferGateInput};
      tgDelay_reg <= tgSync_reg[1];
    end
  end

  assign lsLevel   = lsSync_reg[1];
  assign tgLevel   = tgSync_reg[1];
  assign startCond = lsLevel && tgLevel;
  assign tgRise    = tgLevel && !tgDelay_reg;
  assign monoMode  = ctrl_reg[`LSPWM_CTRL_MONO];
  assign lastState = ctrl_reg[`LSPWM_CTRL_LAST +: 2];

  // ----------------------------------------------------------------------
  // sequence state machine
  // ----------------------------------------------------------------------
  assign advance = monoMode ? enableDone : (tgRise && !lsLevel);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seqIdx_reg <= 2'h0;
      done_reg   <= 1'b1;
    end else if (startCond) begin
      seqIdx_reg <= 2'h0;
      done_reg   <= 1'b0;
    end else if (advance && !done_reg) begin
      if (seqIdx_reg >= lastState) begin
        done_reg <= 1'b1;
      end else begin
        seqIdx_reg <= seqIdx_reg + 2'h1;
      end
    end
  end

  assign mapSel = map_reg[{seqIdx_reg, 1'b0} +: 2];

  // ----------------------------------------------------------------------
  // blanking window after every state change
  // ----------------------------------------------------------------------
  assign blankStart = tgRise || (monoMode && enableDone && !done_reg);
  assign blank      = (blankCnt_reg != 16'h0000);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      blankCnt_reg <= 16'h0000;
    end else if (blankStart) begin
      blankCnt_reg <= BLANK_CYC;
    end else if (blank) begin
      blankCnt_reg <= blankCnt_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // duty and range by selected colour
  // ----------------------------------------------------------------------
  always @* begin
    duty_next  = {PER_W{1'b0}};
    range_next = idac_reg[`LSPWM_IDAC_RNG_R +: 2];
    case (mapSel)
      `LSPWM_MAP_RED: begin
        duty_next  = dutyR_reg[PER_W-1:0];
        range_next = idac_reg[`LSPWM_IDAC_RNG_R +: 2];
      end
      `LSPWM_MAP_GREEN: begin
        duty_next  = dutyG_reg[PER_W-1:0];
        range_next = idac_reg[`LSPWM_IDAC_RNG_G +: 2];
      end
      `LSPWM_MAP_BLUE: begin
        duty_next  = dutyB_reg[PER_W-1:0];
        range_next = idac_reg[`LSPWM_IDAC_RNG_B +: 2];
      end
      default: begin
        duty_next  = {PER_W{1'b0}};
        range_next = ledCurrentRange;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // modulation
  // ----------------------------------------------------------------------
  lspwm_pulse_gen #(
    .DIV_W (DIV_W),
    .PER_W (PER_W),
    .EN_W  (EN_W)
  ) u_pulse (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .restart    (blank || startCond || done_reg),
    .divider    (period_reg[`LSPWM_PERIOD_DIV +: DIV_W]),
    .period     (period_reg[PER_W-1:0]),
    .duty       (duty_next),
    .enFirst    (enable_reg[EN_W-1:0]),
    .enLast     (enable_reg[`LSPWM_ENABLE_LAST +: EN_W]),
    .pulseLevel (pulseLevel),
    .pulseGate  (pulseGate),
    .enableDone (enableDone)
  );

  // ----------------------------------------------------------------------
  // led switch matrix and current outputs
  // ----------------------------------------------------------------------
  assign lit = !done_reg && !blank && pulseGate && pulseLevel;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ledRedOn        <= 1'b0;
      ledGreenOn      <= 1'b0;
      ledBlueOn       <= 1'b0;
      shuntOn         <= 1'b1;
      idacCode        <= 8'h00;
      ledCurrentRange <= 2'h0;
      blankActive     <= 1'b0;
    end else begin
      ledRedOn        <= lit && (mapSel == `LSPWM_MAP_RED);
      ledGreenOn      <= lit && (mapSel == `LSPWM_MAP_GREEN);
      ledBlueOn       <= lit && (mapSel == `LSPWM_MAP_BLUE);
      shuntOn         <= !(lit && (mapSel != `LSPWM_MAP_OFF));
      idacCode        <= idac_reg[7:0];
      ledCurrentRange <= range_next;
      blankActive     <= blank;
    end
  end

endmodule

// ===== common/lspwm_regs.vh
// register map, field positions, reset values and timing of the led sequencer
`ifndef LSPWM_REGS_VH
`define LSPWM_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LSPWM_ADDR_CTRL    8'h00
`define LSPWM_ADDR_MAP     8'h04
`define LSPWM_ADDR_IDAC    8'h08
`define LSPWM_ADDR_PERIOD  8'h0C
`define LSPWM_ADDR_DUTY_R  8'h10
`define LSPWM_ADDR_DUTY_G  8'h14
`define LSPWM_ADDR_DUTY_B  8'h18
`define LSPWM_ADDR_ENABLE  8'h1C
`define LSPWM_ADDR_STATUS  8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LSPWM_CTRL_MONO    0
`define LSPWM_CTRL_LAST    1
`define LSPWM_IDAC_RNG_R   8
`define LSPWM_IDAC_RNG_G   10
`define LSPWM_IDAC_RNG_B   12
`define LSPWM_PERIOD_DIV   12
`define LSPWM_ENABLE_LAST  8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LSPWM_RST_CTRL     32'h0000_0006
`define LSPWM_RST_MAP      32'h0000_00E4
`define LSPWM_RST_IDAC     32'h0000_0000
`define LSPWM_RST_PERIOD   32'h0000_0FFF
`define LSPWM_RST_DUTY     32'h0000_0FFF
`define LSPWM_RST_ENABLE   32'h0000_7F00

// ----------------------------------------------------------------------
// state mapping codes
// ----------------------------------------------------------------------
`define LSPWM_MAP_RED      2'h0
`define LSPWM_MAP_GREEN    2'h1
`define LSPWM_MAP_BLUE     2'h2
`define LSPWM_MAP_OFF      2'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LSPWM_CLK_MHZ      50
`define LSPWM_BLANK_US     25
`define LSPWM_BLANK_CYC    (`LSPWM_BLANK_US * `LSPWM_CLK_MHZ)

`endif

// ===== src/lspwm_pulse_gen.v
// clock divider, modulation counter and enable counter
`timescale 1ns/10ps
module lspwm_pulse_gen #(
  parameter DIV_W = 4,
  parameter PER_W = 12,
  parameter EN_W  = 7
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire             restart,
  input  wire [DIV_W-1:0] divider,
  input  wire [PER_W-1:0] period,
  input  wire [PER_W-1:0] duty,
  input  wire [EN_W-1:0]  enFirst,
  input  wire [EN_W-1:0]  enLast,
  output wire             pulseLevel,
  output wire             pulseGate,
  output reg              enableDone
);

  reg  [DIV_W-1:0] divCnt_reg;
  reg  [PER_W-1:0] pwmCnt_reg;
  reg  [EN_W-1:0]  enCnt_reg;
  wire             tick;
  wire             wrap;

  assign tick = (divCnt_reg == divider);
  assign wrap = tick && (pwmCnt_reg >= period);

  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= {DIV_W{1'b0}};
      pwmCnt_reg <= {PER_W{1'b0}};
      enCnt_reg  <= {EN_W{1'b0}};
      enableDone <= 1'b0;
    end else if (restart) begin
      divCnt_reg <= {DIV_W{1'b0}};
      pwmCnt_reg <= {PER_W{1'b0}};
      enCnt_reg  <= {EN_W{1'b0}};
      enableDone <= 1'b0;
    end else begin
      enableDone <= 1'b0;
      if (tick) begin
        divCnt_reg <= {DIV_W{1'b0}};
      end else begin
        divCnt_reg <= divCnt_reg + 1'b1;
      end
      if (wrap) begin
        pwmCnt_reg <= {PER_W{1'b0}};
        if (enCnt_reg < enLast) begin
          enCnt_reg <= enCnt_reg + 1'b1;
          enableDone <= (enCnt_reg + 1'b1 == enLast);
        end
      end else if (tick) begin
        pwmCnt_reg <= pwmCnt_reg + 1'b1;
      end
    end
  end

  assign pulseLevel = (pwmCnt_reg < duty);
  // gate open from the first count until the last count
  assign pulseGate  = (enCnt_reg >= enFirst) && (enCnt_reg < enLast);

endmodule

// ===== dv/lspwm_ctrl_checker.sv
// port assertions for the led sequencer
`timescale 1ns/10ps
`include "lspwm_regs.vh"
module lspwm_ctrl_checker (
  input wire clk_sys,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire transferGateInput,
  input wire ledRedOn,
  input wire ledGreenOn,
  input wire ledBlueOn,
  input wire shuntOn,
  input wire blankActive
);
  reg  [11:0] blankLen_reg;
  wire        anyLed = ledRedOn | ledGreenOn | ledBlueOn;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles spent in the current blanking window
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      blankLen_reg <= 12'h000;
    else if (!blankActive)
      blankLen_reg <= 12'h000;
    else if (blankLen_reg != 12'hFFF)
      blankLen_reg <= blankLen_reg + 12'h001;
  end
  sequence tgRise;
    !transferGateInput ##1 transferGateInput;
  endsequence
  sequence blankHeld;
    blankActive [*3];
  endsequence
  ack_resp_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  one_led_a:
    assert property ($onehot0({ledRedOn, ledGreenOn, ledBlueOn}))
    else $error("two leds lit");
  current_path_a:
    assert property (!anyLed |-> shuntOn)
    else $error("no path for led current");
  blank_start_a:
    assert property (tgRise |-> ##[1:4] blankActive)
    else $error("no blanking after gate rise");
  blank_dark_a:
    assert property (blankHeld |-> !anyLed)
    else $error("led lit during blanking");
  blank_len_a:
    assert property ($fell(blankActive) |-> blankLen_reg >= `LSPWM_BLANK_CYC)
    else $error("blanking too short");
endmodule
bind lspwm_ctrl lspwm_ctrl_checker chk (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .transferGateInput(transferGateInput), .ledRedOn(ledRedOn),
  .ledGreenOn(ledGreenOn), .ledBlueOn(ledBlueOn), .shuntOn(shuntOn),
  .blankActive(blankActive)
);

// ===== dv/lspwm_scan_model.sv
// scan controller model driving line-start and transfer-gate
`timescale 1ns/10ps
module lspwm_scan_model (
  input  wire clk_sys,
  output reg  lineStartOut = 1'b0,
  output reg  transferGateOut = 1'b0
);
  // both pins high together restart the sequence
  task start_line;
    begin
      @(posedge clk_sys);
      lineStartOut <= 1'b1;
      transferGateOut <= 1'b1;
      repeat (3) @(posedge clk_sys);
      lineStartOut <= 1'b0;
      transferGateOut <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // gate pulse with line-start low, held over several edges
  task gate_pulse;
    begin
      @(posedge clk_sys);
      transferGateOut <= 1'b1;
      repeat (3) @(posedge clk_sys);
      transferGateOut <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== dv/lspwm_ctrl_test.sv
// self-checking bench for the led sequencer
`timescale 1ns/10ps
`include "lspwm_regs.vh"
module lspwm_ctrl_test;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg         wbCyc = 1'b0;
  reg         wbWe = 1'b0;
  reg  [7:0]  wbAdr = 8'h00;
  reg  [3:0]  wbSel = 4'hF;
  reg  [31:0] wbDatW = 32'h0;
  reg  [31:0] rd = 32'h0;
  wire [31:0] wbDatR;
  wire        wbAck;
  wire        lineStart;
  wire        gate;
  wire        ledR;
  wire        ledG;
  wire        ledB;
  wire        shunt;
  wire [7:0]  idac;
  wire [1:0]  ledRange;
  wire        blank;
  integer     err_total = 0;
  integer     samples_checked = 0;
  lspwm_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .lineStartInput(lineStart), .transferGateInput(gate), .ledRedOn(ledR),
    .ledGreenOn(ledG), .ledBlueOn(ledB), .shuntOn(shunt), .idacCode(idac),
    .ledCurrentRange(ledRange), .blankActive(blank));
  lspwm_scan_model scan (.clk_sys(clk_sys), .lineStartOut(lineStart),
    .transferGateOut(gate));
  always #10 clk_sys = ~clk_sys;
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_up;
    begin
      err_total = err_total + 1;
      $display("BAD %0t wait ran out", $time);
      give_verdict;
    end
  endtask
  // one classic cycle, stb tied to cyc, held until ack is sampled
  task wb(input we, input [7:0] a, input [3:0] sel, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= sel;
      wbDatW <= d;
      n = 0;
      do begin
        @(posedge clk_sys);
        n = n + 1;
      end while (wbAck !== 1'b1 && n < 20);
      if (wbAck !== 1'b1)
        give_up;
      rd = wbDatR;
      wbCyc <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(1'b1, a, 4'hF, d);
  endtask
  task rdr(input [7:0] a);
    wb(1'b0, a, 4'hF, 32'h0);
  endtask
  // wait out the blanking window, then watch the leds for 40 cycles
  task step(input [1:0] idx, input done, input [2:0] led,
            input integer lo, input integer hi, input [1:0] rng);
    integer n;
    integer lit;
    integer bad;
    begin
      n = 0;
      while (blank !== 1'b1 && n < 12) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      check(blank, 1'b1);
      n = 0;
      while (blank === 1'b1 && n < 1400) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (blank === 1'b1)
        give_up;
      repeat (4) @(posedge clk_sys);
      lit = 0;
      bad = 0;
      repeat (40) begin
        @(posedge clk_sys);
        if (({ledB, ledG, ledR} & led) !== 3'h0)
          lit = lit + 1;
        if (({ledB, ledG, ledR} & ~led) !== 3'h0)
          bad = bad + 1;
        if (led !== 3'h0 && ledRange !== rng)
          bad = bad + 1;
        if (shunt !== ~|{ledB, ledG, ledR})
          bad = bad + 1;
      end
      check(bad, 0);
      check(lit >= lo && lit <= hi, 1);
      rdr(8'h20);
      check(rd[2:0], {done, idx});
    end
  endtask
  task sc_reset;
    reg [7:0]  a;
    reg [31:0] e;
    begin
      check({shunt, ledR, ledG, ledB}, 4'h8);
      for (a = 8'h00; a < 8'h20; a = a + 8'h04) begin
        e = a == 8'h00 ? `LSPWM_RST_CTRL : a == 8'h04 ? `LSPWM_RST_MAP :
            a == 8'h08 ? `LSPWM_RST_IDAC : a == 8'h0C ? `LSPWM_RST_PERIOD :
            a < 8'h1C ? `LSPWM_RST_DUTY : `LSPWM_RST_ENABLE;
        rdr(a);
        check(rd, e);
      end
      wr(8'h20, 32'h0);
      rdr(8'h20);
      check(rd[2:0], 3'h4);
      wr(8'h24, 32'hFFFF_FFFF);
      rdr(8'h24);
      check(rd, 32'h0);
      wb(1'b1, 8'h08, 4'h1, 32'hFFFF_FFFF);
      rdr(8'h08);
      check(rd, 32'h0000_00FF);
    end
  endtask
  // map: state0 green, state1 blue, state2 red, state3 off
  task sc_colour;
    begin
      wr(8'h04, 32'h0000_00C9);
      wr(8'h08, 32'h0000_395A);
      wr(8'h0C, 32'h0000_0003);
      wr(8'h14, 32'h0000_0002);
      scan.start_line;
      step(2'h0, 1'b0, 3'h2, 18, 22, 2'h2);
      check(idac, 8'h5A);
      scan.gate_pulse;
      step(2'h1, 1'b0, 3'h4, 40, 40, 2'h3);
      scan.start_line;
      step(2'h0, 1'b0, 3'h2, 18, 22, 2'h2);
      scan.gate_pulse;
      step(2'h1, 1'b0, 3'h4, 40, 40, 2'h3);
      scan.gate_pulse;
      step(2'h2, 1'b0, 3'h1, 40, 40, 2'h1);
      scan.gate_pulse;
      step(2'h3, 1'b0, 3'h0, 0, 0, 2'h0);
      scan.gate_pulse;
      step(2'h3, 1'b1, 3'h0, 0, 0, 2'h0);
      scan.gate_pulse;
      step(2'h3, 1'b1, 3'h0, 0, 0, 2'h0);
    end
  endtask
  task sc_length;
    begin
      wr(8'h00, 32'h0000_0002);
      scan.start_line;
      step(2'h0, 1'b0, 3'h2, 18, 22, 2'h2);
      scan.gate_pulse;
      step(2'h1, 1'b0, 3'h4, 40, 40, 2'h3);
      scan.gate_pulse;
      step(2'h1, 1'b1, 3'h0, 0, 0, 2'h0);
      wr(8'h00, 32'h0000_0000);
      scan.start_line;
      step(2'h0, 1'b0, 3'h2, 18, 22, 2'h2);
      scan.gate_pulse;
      step(2'h0, 1'b1, 3'h0, 0, 0, 2'h0);
    end
  endtask
  // mono, two states, two modulation periods each, no gate pulses
  task sc_mono;
    integer n;
    begin
      wr(8'h0C, 32'h0000_1003);
      wr(8'h1C, 32'h0000_0200);
      wr(8'h00, 32'h0000_0003);
      scan.start_line;
      rd = 32'h0;
      n = 0;
      while (rd[2] !== 1'b1 && n < 300) begin
        repeat (20) @(posedge clk_sys);
        rdr(8'h20);
        n = n + 1;
      end
      if (rd[2] !== 1'b1)
        give_up;
      check(rd[2:0], 3'h5);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    sc_reset;
    sc_colour;
    sc_length;
    sc_mono;
    give_verdict;
  end
endmodule
